// *** compare_set_alu_ops_test.sv ***
`timescale 1ns/1ps
module compare_set_alu_ops_test;
    typedef struct packed {
        logic we; logic unk; logic flt; logic chk;
        logic [31:0] lo; logic [31:0] loMax; logic [31:0] hi;
    } csa_exp_s;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic issueValid, gprWriteEn, resValid, resWriteEn, unknownOp, laneFault;
    logic [10:0] aluOpcodeField;
    logic [1:0] laneSel;
    logic [7:0] excFlags;
    logic [63:0] srcA, srcB;
    logic [31:0] resLo, resHi;
    csa_exp_s expQ[$];
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;
    integer seed = 76913;
    logic [10:0] ops[15] = '{csa_pkg::OP_FLOAT_GT_UNIT, csa_pkg::OP_FLOAT_GE_UNIT,
        csa_pkg::OP_FLOAT_NE_UNIT, csa_pkg::OP_FLOAT_GT_MASK, csa_pkg::OP_FLOAT_GE_MASK,
        csa_pkg::OP_FLOAT_NE_MASK, csa_pkg::OP_INT_EQ_MASK, csa_pkg::OP_SIGNED_GT_MASK,
        csa_pkg::OP_SIGNED_GE_MASK, csa_pkg::OP_INT_NE_MASK, csa_pkg::OP_UNSIGNED_GT_MASK,
        csa_pkg::OP_UNSIGNED_GE_MASK, csa_pkg::OP_DOUBLE_NE_MASK, csa_pkg::OP_DOUBLE_GT_MASK,
        csa_pkg::OP_DOUBLE_GE_MASK};
    // One number per entry, as double (high) and single (low).
    logic [63:0] vals[7] = '{64'h3ff000003f800000, 64'h4000000040000000, 64'h0,
        64'h8000000080000000, 64'h7ff800007fc00000, 64'hc0000000c0000000, 64'h3ff000003f800000};

    // ----------
    // Clock, design and sequencer
    // ----------
    always #2 sys_clk = ~sys_clk;

    csa_alu_top u_csa_alu_top (.sys_clk(sys_clk), .rst(rst), .issueValid(issueValid),
        .aluOpcodeField(aluOpcodeField), .laneSel(laneSel), .gprWriteEn(gprWriteEn),
        .excFlags(excFlags), .srcA(srcA), .srcB(srcB), .resValid(resValid), .resLo(resLo),
        .resHi(resHi), .resWriteEn(resWriteEn), .unknownOp(unknownOp), .laneFault(laneFault));

    csa_sequencer_model u_csa_sequencer_model (.sys_clk(sys_clk), .issueValid(issueValid),
        .aluOpcodeField(aluOpcodeField), .laneSel(laneSel), .gprWriteEn(gprWriteEn),
        .excFlags(excFlags), .srcA(srcA), .srcB(srcB));

    // ----------
    // Reference model
    // ----------
    function automatic logic isNan(input logic [63:0] x, input bit dbl);
        return dbl ? (x[62:52] == 11'h7ff && x[51:0] != 52'h0)
                   : (x[30:23] == 8'hff && x[22:0] != 23'h0);
    endfunction

    // Ordered compare: returns {gt, eq}; NaN leaves both low, and +0 equals -0.
    function automatic logic [1:0] fcmp(input logic [63:0] a, input logic [63:0] b,
            input bit dbl);
        logic sa, sb, eq, gt;
        logic [62:0] ma, mb;
        sa = dbl ? a[63] : a[31];
        sb = dbl ? b[63] : b[31];
        ma = dbl ? a[62:0] : {32'h0, a[30:0]};
        mb = dbl ? b[62:0] : {32'h0, b[30:0]};
        eq = (ma == mb && sa == sb) || (ma == 63'h0 && mb == 63'h0);
        gt = !eq && (sa == sb ? (sa ? ma < mb : ma > mb) : !sa);
        if (isNan(a, dbl) || isNan(b, dbl)) begin
            eq = 1'h0;
            gt = 1'h0;
        end
        return {gt, eq};
    endfunction

    // Approximations get a wide window; known points narrow it.
    function automatic csa_exp_s predict(input logic [10:0] op, input logic [1:0] lane,
            input logic we, input logic [7:0] fl, input logic [63:0] a, input logic [63:0] b);
        csa_exp_s r;
        logic [1:0] s, d;
        r = '0;
        r.chk = 1'h1;
        s = fcmp(a, b, 1'b0);
        d = fcmp(a, b, 1'b1);
        case (op)
            csa_pkg::OP_FLOAT_GT_UNIT: r.lo = s[1] ? csa_pkg::FLOAT_ONE : 32'h0;
            csa_pkg::OP_FLOAT_GE_UNIT: r.lo = |s ? csa_pkg::FLOAT_ONE : 32'h0;
            csa_pkg::OP_FLOAT_NE_UNIT: r.lo = !s[0] ? csa_pkg::FLOAT_ONE : 32'h0;
            csa_pkg::OP_FLOAT_GT_MASK: r.lo = {32{s[1]}};
            csa_pkg::OP_FLOAT_GE_MASK: r.lo = {32{|s}};
            csa_pkg::OP_FLOAT_NE_MASK: r.lo = {32{!s[0]}};
            csa_pkg::OP_INT_EQ_MASK: r.lo = {32{a[31:0] == b[31:0]}};
            csa_pkg::OP_SIGNED_GT_MASK: r.lo = {32{$signed(a[31:0]) > $signed(b[31:0])}};
            csa_pkg::OP_SIGNED_GE_MASK: r.lo = {32{$signed(a[31:0]) >= $signed(b[31:0])}};
            csa_pkg::OP_INT_NE_MASK: r.lo = {32{a[31:0] != b[31:0]}};
            csa_pkg::OP_UNSIGNED_GT_MASK: r.lo = {32{a[31:0] > b[31:0]}};
            csa_pkg::OP_UNSIGNED_GE_MASK: r.lo = {32{a[31:0] >= b[31:0]}};
            csa_pkg::OP_DOUBLE_NE_MASK: r.lo = {32{!d[0]}};
            csa_pkg::OP_DOUBLE_GT_MASK: r.lo = {32{d[1]}};
            csa_pkg::OP_DOUBLE_GE_MASK: r.lo = {32{|d}};
            csa_pkg::OP_SQRT_SINGLE: r.lo = (a[31:0] == csa_pkg::FLOAT_ONE) ? a[31:0] : 32'h0;
            csa_pkg::OP_SQRT_DOUBLE: r.lo = ({a[31:0], b[31:0]} == 64'h3ff0000000000000)
                ? csa_pkg::DOUBLE_ONE_HI : 32'h0;
            csa_pkg::OP_WAVE_APPROX: r.lo = 32'h0;
            csa_pkg::OP_STORE_FLAGS: begin
                r.lo = {24'h0, fl};
                r.flt = (lane != 2'h3);
                r.chk = !r.flt;
            end
            default: r.unk = 1'h1;
        endcase
        r.loMax = r.lo;
        if ((op == csa_pkg::OP_SQRT_SINGLE || op == csa_pkg::OP_SQRT_DOUBLE) && r.lo == 32'h0)
            r.loMax = 32'hffffffff;
        if (op == csa_pkg::OP_WAVE_APPROX && a[30:0] <= 31'h43800000)
            r.loMax = 32'hffffffff;
        if (op == csa_pkg::OP_DOUBLE_NE_MASK || op == csa_pkg::OP_DOUBLE_GT_MASK
                || op == csa_pkg::OP_DOUBLE_GE_MASK)
            r.hi = r.lo;
        r.we = we && !r.unk && !r.flt;
        return r;
    endfunction

    // ----------
    // Driving side
    // ----------
    // Issues one operation and queues its expected result.
    task automatic send(input logic [10:0] op, input logic [1:0] lane, input logic we,
            input logic [7:0] fl, input logic [63:0] a, input logic [63:0] b,
            input bit brk = 1'b0, input logic [31:0] rLo = 32'h0, input logic [31:0] rHi = 32'h0);
        logic [1:0] ln;
        csa_exp_s e;
        u_csa_sequencer_model.issue(op, lane, we, fl, a, b, brk, ln);
        e = predict(op, ln, we, fl, a, b);
        if (rHi != 32'h0) begin
            e.lo = rLo;
            e.loMax = rHi;
        end
        expQ.push_back(e);
    endtask

    task automatic check(input logic [67:0] seen, input logic [67:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------
    // Watching side
    // ----------
    // Sampled on the falling edge, where registered outputs have settled.
    always @(negedge sys_clk) begin
        csa_exp_s e;
        if (!rst && resValid === 1'h1) begin
            if (expQ.size() == 0) begin
                check(64'h1, 64'h0, "result without issue");
            end else begin
                e = expQ.pop_front();
                check({resWriteEn, unknownOp, laneFault}, {e.we, e.unk, e.flt}, "flags");
                check(resHi, e.hi, "high word");
                if (e.chk)
                    check(resLo >= e.lo && resLo <= e.loMax, 1'h1, "low word");
            end
        end
    end

    // A hang counts as a failure and goes to the same closing report.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            end_sim();
        end
    end

    // ----------
    // Main sequence
    // ----------
    initial begin
        repeat (12) @(negedge sys_clk);
        check({resValid, resWriteEn, unknownOp, laneFault, resLo, resHi}, 68'h0, "reset");
        rst = 1'h0;
        send(csa_pkg::OP_INT_EQ_MASK, 2'h0, 1'h1, 8'h00, 64'h5, 64'h5);
        send(csa_pkg::OP_INT_EQ_MASK, 2'h1, 1'h1, 8'h00, 64'h5, 64'h4);
        // Every compare against every pair of edge values, back to back.
        foreach (ops[k])
            foreach (vals[i])
                foreach (vals[j])
                    send(ops[k], 2'(i), 1'h1, 8'h00, vals[i], vals[j]);
        // Flag store in lane w with and without write, then in the wrong lanes.
        send(csa_pkg::OP_STORE_FLAGS, 2'h3, 1'h1, 8'h12, 64'h0, 64'h0);
        send(csa_pkg::OP_STORE_FLAGS, 2'h3, 1'h0, 8'ha5, 64'h0, 64'h0);
        for (int l = 0; l < 3; l++)
            send(csa_pkg::OP_STORE_FLAGS, 2'(l), 1'h1, 8'h3c, 64'h0, 64'h0, 1'b1);
        // Opcodes this block does not own, including the misprinted sine code.
        send(11'h0d8, 2'h0, 1'h1, 8'h00, 64'h1, 64'h1);
        send(11'h008, 2'h0, 1'h1, 8'h00, 64'h1, 64'h1);
        send(11'h7ff, 2'h0, 1'h1, 8'h00, 64'h1, 64'h1);
        u_csa_sequencer_model.idle();
        // Approximations at known points and at the edges of the sine range.
        send(csa_pkg::OP_SQRT_SINGLE, 2'h0, 1'h1, 8'h00, 64'h3f800000, 64'h0);
        send(csa_pkg::OP_SQRT_SINGLE, 2'h0, 1'h1, 8'h00, 64'h40800000, 64'h0, 1'b0,
            32'h3fe00000, 32'h40200000);
        send(csa_pkg::OP_SQRT_DOUBLE, 2'h0, 1'h1, 8'h00, 64'h3ff00000, 64'h0);
        send(csa_pkg::OP_SQRT_DOUBLE, 2'h0, 1'h1, 8'h00, 64'h40100000, 64'h0, 1'b0,
            32'h3ffe0000, 32'h40020000);
        send(csa_pkg::OP_WAVE_APPROX, 2'h0, 1'h1, 8'h00, 64'h3e800000, 64'h0, 1'b0,
            32'h3f666666, 32'h3f8ccccd);
        send(csa_pkg::OP_WAVE_APPROX, 2'h0, 1'h1, 8'h00, 64'h43804000, 64'h0);
        send(csa_pkg::OP_WAVE_APPROX, 2'h0, 1'h1, 8'h00, 64'hc3960000, 64'h0);
        // Random operands, lanes and write enables over the compare opcodes.
        repeat (300)
            send(ops[$unsigned($random(seed)) % 15], 2'($random(seed)), 1'($random(seed)),
                8'($random(seed)), {$random(seed), $random(seed)}, {$random(seed), $random(seed)});
        u_csa_sequencer_model.idle();
        repeat (4) @(negedge sys_clk);
        check(expQ.size(), 64'h0, "missing results");
        end_sim();
    end
endmodule

// *** csa_alu_top.sv ***
`timescale 1ns/1ps
// Function
// - Opcode 58 decodes as integer equality mask.
// - Equal operands give all ones, else zero.
// - Float greater-or-equal writes one or zero.
// - Float greater-than writes one or zero.
// - Float not-equal writes one or zero.
// - Float greater-or-equal writes integer mask.
// - Float greater-than writes integer mask.
// - Float not-equal writes integer mask.
// - Signed greater-or-equal writes integer mask.
// - Signed greater-than writes integer mask.
// - Unsigned greater-or-equal writes integer mask.
// - Unsigned greater-than writes integer mask.
// - Integer not-equal writes mask, any signedness.
// - Double greater-or-equal mask, predicate untouched.
// - Double greater-than mask, predicate untouched.
// - Double not-equal mask, predicate untouched.
// - Sine approximation of input in turns.
// - Sine input outside 256 turns gives zero.
// - Double square root returns high word only.
// - Square root of exactly one is one.
// - Flag store writes only with write enable.
// - Opcode 218 decodes as flag store.
module csa_alu_top #(
    parameter int EXC_W = csa_pkg::EXC_FLAGS_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic issueValid,
    input wire logic [10:0] aluOpcodeField,
    input wire logic [1:0] laneSel,
    input wire logic gprWriteEn,
    input wire logic [EXC_W-1:0] excFlags,
    input wire logic [63:0] srcA,
    input wire logic [63:0] srcB,
    output logic resValid,
    output logic [31:0] resLo,
    output logic [31:0] resHi,
    output logic resWriteEn,
    output logic unknownOp,
    output logic laneFault
);

    // ----------
    // State
    // ----------
    typedef struct packed {
        logic valid;
        logic [31:0] lo;
        logic [31:0] hi;
        logic wr;
        logic unk;
        logic fault;
    } csa_state_s;

    csa_state_s state_r;
    csa_state_s state_nxt;

    logic fGt;
    logic fEq;
    logic fUn;
    logic dGt;
    logic dEq;
    logic dUn;
    logic [31:0] waveRes;
    logic [31:0] sqrtRes;
    logic [31:0] sqrtDblRes;

    // A true condition becomes an all-ones word, a false one zero.
    function automatic logic [31:0] to_mask(input logic cond);
        return cond ? 32'hffffffff : 32'h00000000;
    endfunction

    // A true condition becomes float one, a false one float zero.
    function automatic logic [31:0] to_unit(input logic cond);
        return cond ? csa_pkg::FLOAT_ONE : csa_pkg::FLOAT_ZERO;
    endfunction

    // ----------
    // Arithmetic units
    // ----------
    // Single and double compares share one parameterised comparator.
    csa_fp_compare #(.EXP_W(8), .MAN_W(23)) u_cmp_single (
        .opA(srcA[31:0]),
        .opB(srcB[31:0]),
        .aGtB(fGt),
        .aEqB(fEq),
        .unordered(fUn)
    );

    csa_fp_compare #(.EXP_W(11), .MAN_W(52)) u_cmp_double (
        .opA(srcA),
        .opB(srcB),
        .aGtB(dGt),
        .aEqB(dEq),
        .unordered(dUn)
    );

    // The double root takes its high bits from the first operand and its
    // low bits from the second, each in the low word of its lane.
    csa_approx_unit u_approx (
        .singleIn(srcA[31:0]),
        .doubleIn({srcA[31:0], srcB[31:0]}),
        .waveOut(waveRes),
        .sqrtSingleOut(sqrtRes),
        .sqrtDoubleHi(sqrtDblRes)
    );

    // ----------
    // Decode and result select
    // ----------
    // One result per issue, one cycle later. None of these operations
    // touches a predicate, so the block has no predicate output at all.
    always_comb begin
        state_nxt = state_r;
        state_nxt.valid = issueValid;
        state_nxt.unk = 1'b0;
        state_nxt.fault = 1'b0;
        state_nxt.wr = 1'b0;
        if (issueValid) begin
            state_nxt.lo = 32'h0;
            state_nxt.hi = 32'h0;
            state_nxt.wr = gprWriteEn;
            unique case (aluOpcodeField)
                csa_pkg::OP_INT_EQ_MASK: begin
                    state_nxt.lo = to_mask(srcA[31:0] == srcB[31:0]);
                end

                csa_pkg::OP_FLOAT_GE_UNIT: begin
                    state_nxt.lo = to_unit(fGt || fEq);
                end

                csa_pkg::OP_FLOAT_GT_UNIT: begin
                    state_nxt.lo = to_unit(fGt);
                end

                csa_pkg::OP_FLOAT_NE_UNIT: begin
                    state_nxt.lo = to_unit(!fEq);
                end

                csa_pkg::OP_FLOAT_GE_MASK: begin
                    state_nxt.lo = to_mask(fGt || fEq);
                end

                csa_pkg::OP_FLOAT_GT_MASK: begin
                    state_nxt.lo = to_mask(fGt);
                end

                csa_pkg::OP_FLOAT_NE_MASK: begin
                    state_nxt.lo = to_mask(!fEq);
                end

                csa_pkg::OP_SIGNED_GE_MASK: begin
                    state_nxt.lo = to_mask($signed(srcA[31:0]) >= $signed(srcB[31:0]));
                end

                csa_pkg::OP_SIGNED_GT_MASK: begin
                    state_nxt.lo = to_mask($signed(srcA[31:0]) > $signed(srcB[31:0]));
                end

                csa_pkg::OP_UNSIGNED_GE_MASK: begin
                    state_nxt.lo = to_mask(srcA[31:0] >= srcB[31:0]);
                end

                csa_pkg::OP_UNSIGNED_GT_MASK: begin
                    state_nxt.lo = to_mask(srcA[31:0] > srcB[31:0]);
                end

                csa_pkg::OP_INT_NE_MASK: begin
                    state_nxt.lo = to_mask(srcA[31:0] != srcB[31:0]);
                end

                csa_pkg::OP_DOUBLE_GE_MASK: begin
                    state_nxt.lo = to_mask(dGt || dEq);
                    state_nxt.hi = to_mask(dGt || dEq);
                end

                csa_pkg::OP_DOUBLE_GT_MASK: begin
                    state_nxt.lo = to_mask(dGt);
                    state_nxt.hi = to_mask(dGt);
                end

                csa_pkg::OP_DOUBLE_NE_MASK: begin
                    state_nxt.lo = to_mask(!dEq);
                    state_nxt.hi = to_mask(!dEq);
                end

                csa_pkg::OP_WAVE_APPROX: begin
                    state_nxt.lo = waveRes;
                end

                csa_pkg::OP_SQRT_DOUBLE: begin
                    state_nxt.lo = sqrtDblRes;
                end

                csa_pkg::OP_SQRT_SINGLE: begin
                    state_nxt.lo = sqrtRes;
                end

                csa_pkg::OP_STORE_FLAGS: begin
                    // A flag store outside lane w is a sequencer fault; the
                    // write is dropped rather than landing in a wrong lane.
                    state_nxt.lo = 32'(excFlags);
                    state_nxt.fault = (laneSel != csa_pkg::LANE_W);
                    state_nxt.wr = gprWriteEn && (laneSel == csa_pkg::LANE_W);
                end

                default: begin
                    state_nxt.unk = 1'b1;
                    state_nxt.wr = 1'b0;
                end
            endcase
        end
    end

    // ----------
    // State register
    // ----------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Every output comes straight from the state register.
    assign resValid = state_r.valid;
    assign resLo = state_r.lo;
    assign resHi = state_r.hi;
    assign resWriteEn = state_r.wr;
    assign unknownOp = state_r.unk;
    assign laneFault = state_r.fault;

    // ----------
    // Checks
    // ----------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_int_eq_mask: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_INT_EQ_MASK
        |=> resLo == ($past(srcA[31:0]) == $past(srcB[31:0]) ? 32'hffffffff : 32'h0))
        else $error("Integer equality mask is wrong.");

    a_unsigned_gt: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_UNSIGNED_GT_MASK
        && srcA[31:0] <= srcB[31:0]
        |=> resLo == 32'h0 && resValid)
        else $error("Unsigned greater-than set for a smaller operand.");

    a_signed_ge: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_SIGNED_GE_MASK
        && srcA[31] && !srcB[31]
        |=> resLo == 32'h0)
        else $error("Signed compare treated a negative operand as large.");

    a_unit_values: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_FLOAT_GE_UNIT && srcA == srcB
        && srcA[30:23] != 8'hff
        |=> resLo == csa_pkg::FLOAT_ONE)
        else $error("Float ge of equal operands is not one.");

    a_nan_not_equal: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_FLOAT_NE_MASK
        && srcA[30:23] == 8'hff && srcA[22:0] != 23'h0
        |=> resLo == 32'hffffffff)
        else $error("Not-equal with NaN operand is not true.");

    a_double_halves: assert property (
        state_r.valid && $past(aluOpcodeField) == csa_pkg::OP_DOUBLE_GE_MASK
        && $past(issueValid)
        |-> resLo == resHi && (resLo == 32'h0 || resLo == 32'hffffffff))
        else $error("Double mask halves disagree.");

    a_flags_gated: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_STORE_FLAGS && !gprWriteEn
        |=> !resWriteEn ##1 !resWriteEn || resValid)
        else $error("Flag store wrote without write enable.");

    a_flags_lane: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_STORE_FLAGS
        && laneSel != csa_pkg::LANE_W
        |=> laneFault && !resWriteEn)
        else $error("Flag store outside lane w was not refused.");

    a_sqrt_one: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_SQRT_SINGLE
        && srcA[31:0] == csa_pkg::FLOAT_ONE
        |=> resLo == csa_pkg::FLOAT_ONE)
        else $error("Square root of one is not exactly one.");

    a_wave_range: assert property (
        issueValid && aluOpcodeField == csa_pkg::OP_WAVE_APPROX
        && srcA[30:23] > csa_pkg::EXP_RANGE_TOP
        |=> resLo == csa_pkg::FLOAT_ZERO)
        else $error("Out-of-range wave input did not give zero.");

    a_one_cycle: assert property (
        issueValid
        |=> resValid ##1 (resValid == $past(issueValid)))
        else $error("Result did not follow issue by one cycle.");

    a_unknown_refused: assert property (
        resValid && unknownOp
        |-> !resWriteEn && resLo == 32'h0 && resHi == 32'h0)
        else $error("Unknown opcode was not refused.");

endmodule

// *** csa_approx_unit.sv ***
`timescale 1ns/1ps
module csa_approx_unit (
    input wire logic [31:0] singleIn,
    input wire logic [63:0] doubleIn,
    output logic [31:0] waveOut,
    output logic [31:0] sqrtSingleOut,
    output logic [31:0] sqrtDoubleHi
);
    logic [39:0] fixWide;
    logic [15:0] turnFrac;
    logic [14:0] halfPos;
    logic [29:0] parab;
    logic [16:0] waveFix;
    logic [7:0] shiftAmt;
    logic inRange;
    logic [63:0] dblSum;

    // Turns a 1.16 fixed value in [0, 1] into a float of the given sign.
    function automatic logic [31:0] fix_to_float(input logic sgn, input logic [16:0] v);
        logic [31:0] f;
        f = {sgn, 31'h0};
        for (int i = 0; i < 17; i++) begin
            if (v[i]) begin
                f = {sgn, 8'(int'(csa_pkg::EXP_BIAS) + i - 16), 23'({6'h0, v} << (23 - i))};
            end
        end
        if (v == 17'h0) begin
            f = csa_pkg::FLOAT_ZERO;
        end
        return f;
    endfunction

    // ----------
    // Periodic wave approximation
    // ----------
    // The input is in turns; only its fraction matters. A parabola per
    // half turn keeps the unit small at a few percent of error.
    always_comb begin
        inRange = (singleIn[30:23] < csa_pkg::EXP_RANGE_TOP) ||
            (singleIn[30:0] == {csa_pkg::EXP_RANGE_TOP, 23'h0});
        if (singleIn[30:23] > (csa_pkg::EXP_FIX_ALIGN - 8'h28)) begin
            shiftAmt = csa_pkg::EXP_FIX_ALIGN - singleIn[30:23];
        end else begin
            shiftAmt = 8'h28;
        end
        fixWide = ({16'h0, 1'b1, singleIn[22:0]} << 16) >> shiftAmt;
        turnFrac = singleIn[31] ? 16'(-fixWide[15:0]) : fixWide[15:0];
        halfPos = turnFrac[14:0];
        parab = 30'(halfPos) * 30'(16'h8000 - {1'b0, halfPos});
        waveFix = parab[28:12];
        if (!inRange || singleIn[30:23] == 8'h0) begin
            waveOut = csa_pkg::FLOAT_ZERO;
        end else begin
            waveOut = fix_to_float(turnFrac[15], waveFix);
        end
    end

    // ----------
    // Square root estimates
    // ----------
    // Exponent halving with a linear mantissa; exact at one by design.
    always_comb begin
        if (singleIn == csa_pkg::FLOAT_ONE) begin
            sqrtSingleOut = csa_pkg::FLOAT_ONE;
        end else if (singleIn[30:0] == 31'h0) begin
            sqrtSingleOut = singleIn;
        end else if (singleIn[31]) begin
            sqrtSingleOut = csa_pkg::FLOAT_QNAN;
        end else begin
            sqrtSingleOut = (singleIn >> 1) + csa_pkg::SQRT_BIAS_SINGLE;
        end
        dblSum = (doubleIn >> 1) + csa_pkg::SQRT_BIAS_DOUBLE;
        if (doubleIn == {csa_pkg::DOUBLE_ONE_HI, 32'h0}) begin
            sqrtDoubleHi = csa_pkg::DOUBLE_ONE_HI;
        end else if (doubleIn[62:0] == 63'h0) begin
            sqrtDoubleHi = doubleIn[63:32];
        end else if (doubleIn[63]) begin
            sqrtDoubleHi = 32'hfff80000;
        end else begin
            sqrtDoubleHi = dblSum[63:32];
        end
    end

endmodule

// *** csa_fp_compare.sv ***
`timescale 1ns/1ps
module csa_fp_compare #(
    parameter int EXP_W = 8,
    parameter int MAN_W = 23
) (
    input wire logic [EXP_W+MAN_W:0] opA,
    input wire logic [EXP_W+MAN_W:0] opB,
    output logic aGtB,
    output logic aEqB,
    output logic unordered
);
    logic nanA;
    logic nanB;
    logic bothZero;
    logic magGt;
    logic signA;
    logic signB;

    // ----------
    // Ordered IEEE relation
    // ----------
    // Signed zeros compare equal; any NaN makes every relation false.
    always_comb begin
        signA = opA[EXP_W+MAN_W];
        signB = opB[EXP_W+MAN_W];
        nanA = (&opA[EXP_W+MAN_W-1:MAN_W]) && (|opA[MAN_W-1:0]);
        nanB = (&opB[EXP_W+MAN_W-1:MAN_W]) && (|opB[MAN_W-1:0]);
        unordered = nanA || nanB;
        bothZero = (opA[EXP_W+MAN_W-1:0] == '0) && (opB[EXP_W+MAN_W-1:0] == '0);
        magGt = opA[EXP_W+MAN_W-1:0] > opB[EXP_W+MAN_W-1:0];
        aEqB = !unordered && ((opA == opB) || bothZero);
        if (unordered || bothZero) begin
            aGtB = 1'b0;
        end else if (signA != signB) begin
            aGtB = !signA;
        end else begin
            aGtB = signA ? (opA[EXP_W+MAN_W-1:0] < opB[EXP_W+MAN_W-1:0]) : magGt;
        end
    end

endmodule

// *** csa_pkg.sv ***
package csa_pkg;

    // ----------
    // Operation codes of the two-source ALU format
    // ----------
    localparam logic [10:0] OP_FLOAT_GT_UNIT = 11'h009;
    localparam logic [10:0] OP_FLOAT_GE_UNIT = 11'h00a;
    localparam logic [10:0] OP_FLOAT_NE_UNIT = 11'h00b;
    localparam logic [10:0] OP_FLOAT_GT_MASK = 11'h00d;
    localparam logic [10:0] OP_FLOAT_GE_MASK = 11'h00e;
    localparam logic [10:0] OP_FLOAT_NE_MASK = 11'h00f;
    localparam logic [10:0] OP_INT_EQ_MASK = 11'h03a;
    localparam logic [10:0] OP_SIGNED_GT_MASK = 11'h03b;
    localparam logic [10:0] OP_SIGNED_GE_MASK = 11'h03c;
    localparam logic [10:0] OP_INT_NE_MASK = 11'h03d;
    localparam logic [10:0] OP_UNSIGNED_GT_MASK = 11'h03e;
    localparam logic [10:0] OP_UNSIGNED_GE_MASK = 11'h03f;
    localparam logic [10:0] OP_SQRT_SINGLE = 11'h08a;
    localparam logic [10:0] OP_WAVE_APPROX = 11'h08d;
    localparam logic [10:0] OP_SQRT_DOUBLE = 11'h099;
    localparam logic [10:0] OP_DOUBLE_NE_MASK = 11'h0b9;
    localparam logic [10:0] OP_DOUBLE_GT_MASK = 11'h0ba;
    localparam logic [10:0] OP_DOUBLE_GE_MASK = 11'h0bb;
    localparam logic [10:0] OP_STORE_FLAGS = 11'h0da;

    // ----------
    // Float constants and layout
    // ----------
    localparam logic [31:0] FLOAT_ONE = 32'h3f800000;
    localparam logic [31:0] FLOAT_ZERO = 32'h00000000;
    localparam logic [31:0] FLOAT_QNAN = 32'h7fc00000;
    localparam logic [31:0] DOUBLE_ONE_HI = 32'h3ff00000;
    localparam logic [31:0] SQRT_BIAS_SINGLE = 32'h1fc00000;
    localparam logic [63:0] SQRT_BIAS_DOUBLE = 64'h1ff8000000000000;
    localparam logic [7:0] EXP_BIAS = 8'h7f;
    localparam logic [7:0] EXP_RANGE_TOP = 8'h87;
    localparam logic [7:0] EXP_FIX_ALIGN = 8'h96;
    localparam logic [1:0] LANE_W = 2'h3;
    localparam int EXC_FLAGS_W = 8;

endpackage

// *** csa_sequencer_model.sv ***
`timescale 1ns/1ps
// ----------
// Sequencer stand-in
// ----------
// On release issueValid drops, gprWriteEn holds and every other line is inverted, so a stale operand never looks live.
module csa_sequencer_model (
    input wire logic sys_clk,
    output logic issueValid,
    output logic [10:0] aluOpcodeField,
    output logic [1:0] laneSel,
    output logic gprWriteEn,
    output logic [7:0] excFlags,
    output logic [63:0] srcA,
    output logic [63:0] srcB
);
    // Everything starts quiet at time zero.
    initial begin
        {issueValid, aluOpcodeField, laneSel, gprWriteEn, excFlags, srcA, srcB} = '0;
    end

    // Flag store goes to lane w unless the caller asks to break that on purpose.
    task automatic issue(input logic [10:0] op, input logic [1:0] lane, input logic we,
            input logic [7:0] flags, input logic [63:0] a, input logic [63:0] b,
            input bit brk, output logic [1:0] laneUsed);
        @(negedge sys_clk);
        laneUsed = (op == csa_pkg::OP_STORE_FLAGS && !brk) ? 2'h3 : lane;
        issueValid = 1'h1;
        aluOpcodeField = op;
        laneSel = laneUsed;
        gprWriteEn = we;
        excFlags = flags;
        srcA = a;
        srcB = b;
    endtask

    // Release the bus and scramble what it carried.
    task automatic idle();
        @(negedge sys_clk);
        issueValid = 1'h0;
        aluOpcodeField = ~aluOpcodeField;
        laneSel = ~laneSel;
        excFlags = ~excFlags;
        srcA = ~srcA;
        srcB = ~srcB;
    endtask
endmodule
